// ### src/iir_ide_irq_routing.sv
// ide interrupt routing, reset straps, rom pins and drive strobes
`timescale 1ns/1ns
`default_nettype none
module iir_ide_irq_routing
#(
  parameter int WrLowCycles = iir_pkg::WR_LOW_CYC,
  parameter int DrvRstCycles = iir_pkg::DRV_RST_CYC
)
(
  input  wire logic                       clock,
  input  wire logic                       drive_soft_reset_bit,
  input  wire logic                       primaryDriveIrqIn,
  input  wire logic                       secondaryDriveIrqIn,
  input  wire logic                       romEnableStrapN,
  input  wire logic                       irqTriggerStrapN,
  input  wire logic                       irqPinoutStrap,
  input  wire logic                       latchPinIn,
  output logic                            latchPinOut,
  output logic                            latchPinOeN,
  input  wire logic                       romSelPinIn,
  output logic                            romSelPinOut,
  output logic                            romSelPinOeN,
  input  wire logic                       legacyMode,
  input  wire logic                       romAddrLoad,
  input  wire logic                       romReadActive,
  input  wire logic                       sysMgmtEvent,
  input  wire logic                       driveResetReq,
  input  wire logic                       hostWriteStart,
  input  wire logic [iir_pkg::DATA_W-1:0] hostWriteData,
  output logic                            hostWriteBusy,
  output logic                            driveWriteStrobeN,
  output logic [iir_pkg::DATA_W-1:0]      driveDataOut,
  output logic                            driveDataOeN,
  output logic                            driveResetOutN,
  output logic                            intaPinOut,
  output logic                            intaPinOeN,
  output logic                            irq15PinOut,
  output logic                            irq15PinOeN,
  output logic                            irq14PinOut,
  output logic                            irq14PinOeN,
  output logic                            secondaryEnabled,
  output logic                            romEnabled,
  output logic                            testModeActive
);
  if (WrLowCycles < 1 || WrLowCycles > 15)
  begin : gWrLowChk
    $error("WrLowCycles out of range");
  end
  if (DrvRstCycles < 1 || DrvRstCycles > 2047)
  begin : gDrvRstChk
    $error("DrvRstCycles out of range");
  end

  logic primIrqSync, secIrqSync, romStrapSync, trigStrapSync;
  logic pinoutStrapSync, chanStrapSync, testStrapSync;
  logic strapsTaken_ff;
  logic chanCfg_ff, romEnN_ff, testN_ff, trigN_ff, pinout_ff;
  logic [iir_pkg::DRV_RST_CNT_W-1:0] rstCnt_ff;
  logic [iir_pkg::WR_CNT_W-1:0] wrCnt_ff;
  iir_pkg::iir_wr_e wrState_ff;
  logic primIrq, secIrq;

  iir_sync2 syncPrim (.clock(clock), .pinIn(primaryDriveIrqIn),
                      .syncOut(primIrqSync));
  iir_sync2 syncSec (.clock(clock), .pinIn(secondaryDriveIrqIn),
                     .syncOut(secIrqSync));
  iir_sync2 syncRom (.clock(clock), .pinIn(romEnableStrapN),
                     .syncOut(romStrapSync));
  iir_sync2 syncTrig (.clock(clock), .pinIn(irqTriggerStrapN),
                      .syncOut(trigStrapSync));
  iir_sync2 syncPinout (.clock(clock), .pinIn(irqPinoutStrap),
                        .syncOut(pinoutStrapSync));
  iir_sync2 syncChan (.clock(clock), .pinIn(latchPinIn),
                      .syncOut(chanStrapSync));
  iir_sync2 syncTest (.clock(clock), .pinIn(romSelPinIn),
                      .syncOut(testStrapSync));

  // capture once
  // synchronised values still show levels seen during reset, since the
  // shared pins stay undriven until straps are taken
  always_ff @(posedge clock)
  begin
    if (drive_soft_reset_bit)
    begin
      strapsTaken_ff <= 1'b0;
      chanCfg_ff     <= iir_pkg::RST_CHAN_CFG;
      romEnN_ff      <= iir_pkg::RST_ROM_EN_N;
      testN_ff       <= iir_pkg::RST_TEST_N;
      trigN_ff       <= iir_pkg::RST_TRIG_N;
      pinout_ff      <= iir_pkg::RST_PINOUT;
    end
    else if (!strapsTaken_ff)
    begin
      strapsTaken_ff <= 1'b1;
      chanCfg_ff     <= chanStrapSync;
      romEnN_ff      <= romStrapSync;
      testN_ff       <= testStrapSync;
      pinout_ff      <= pinoutStrapSync;
      // trigger strap, ignored unless compatible pinout
      trigN_ff       <= pinoutStrapSync ? trigStrapSync
                                        : iir_pkg::RST_TRIG_N;
    end
  end

  assign secondaryEnabled = (chanCfg_ff == iir_pkg::CHAN_BOTH);
  assign romEnabled       = (romEnN_ff == iir_pkg::ROM_ENABLED);
  assign testModeActive   = strapsTaken_ff &&
                            (testN_ff == iir_pkg::TEST_MODE);

  // drive inputs are trusted as level requests
  assign primIrq = primIrqSync;
  // secondary channel off when strap says primary only
  assign secIrq  = secIrqSync && secondaryEnabled;

  // power-on drive reset and later re-trigger
  always_ff @(posedge clock)
  begin
    if (drive_soft_reset_bit || driveResetReq)
    begin
      rstCnt_ff      <= DrvRstCycles[iir_pkg::DRV_RST_CNT_W-1:0];
      driveResetOutN <= 1'b0;
    end
    else if (rstCnt_ff > 1)
      rstCnt_ff <= rstCnt_ff - 1'b1;
    else
    begin
      rstCnt_ff      <= '0;
      driveResetOutN <= 1'b1;
    end
  end

  // write strobe sequencing
  // data is held one cycle past the rising edge for drive hold time
  always_ff @(posedge clock)
  begin
    if (drive_soft_reset_bit)
    begin
      wrState_ff        <= iir_pkg::IIR_WR_IDLE;
      wrCnt_ff          <= '0;
      driveWriteStrobeN <= 1'b1;
      driveDataOeN      <= 1'b1;
      driveDataOut      <= '0;
    end
    else
    begin
      unique case (wrState_ff)
        iir_pkg::IIR_WR_IDLE:
        begin
          if (hostWriteStart)
          begin
            wrState_ff        <= iir_pkg::IIR_WR_STROBE;
            wrCnt_ff          <= WrLowCycles[iir_pkg::WR_CNT_W-1:0];
            driveWriteStrobeN <= 1'b0;
            driveDataOeN      <= 1'b0;
            driveDataOut      <= hostWriteData;
          end
        end
        iir_pkg::IIR_WR_STROBE:
        begin
          if (wrCnt_ff > 1)
            wrCnt_ff <= wrCnt_ff - 1'b1;
          else
          begin
            wrState_ff        <= iir_pkg::IIR_WR_HOLD;
            driveWriteStrobeN <= 1'b1;
          end
        end
        iir_pkg::IIR_WR_HOLD:
        begin
          wrState_ff   <= iir_pkg::IIR_WR_IDLE;
          driveDataOeN <= 1'b1;
        end
        default:
        begin
          wrState_ff        <= iir_pkg::IIR_WR_IDLE;
          driveWriteStrobeN <= 1'b1;
          driveDataOeN      <= 1'b1;
        end
      endcase
    end
  end
  assign hostWriteBusy = (wrState_ff != iir_pkg::IIR_WR_IDLE);

  // address latch pulse, one cycle per load
  always_ff @(posedge clock)
  begin
    if (drive_soft_reset_bit)
    begin
      latchPinOut <= 1'b0;
      latchPinOeN <= 1'b1;
    end
    else
    begin
      latchPinOeN <= !strapsTaken_ff;
      latchPinOut <= romEnabled && strapsTaken_ff && romAddrLoad &&
                     !latchPinOut;
    end
  end

  // shared pin function chosen by rom strap
  always_ff @(posedge clock)
  begin
    if (drive_soft_reset_bit)
    begin
      romSelPinOut <= 1'b1;
      romSelPinOeN <= 1'b1;
    end
    else
    begin
      romSelPinOeN <= !strapsTaken_ff;
      if (romEnabled)
        romSelPinOut <= !romReadActive;
      else
        romSelPinOut <= !sysMgmtEvent;
    end
  end

  // interrupt pin routing
  // pins stay tristated until straps are known to avoid glitching irqs
  always_ff @(posedge clock)
  begin
    if (drive_soft_reset_bit || !strapsTaken_ff)
    begin
      intaPinOut  <= 1'b1;
      intaPinOeN  <= 1'b1;
      irq15PinOut <= 1'b0;
      irq15PinOeN <= 1'b1;
      irq14PinOut <= 1'b0;
      irq14PinOeN <= 1'b1;
    end
    else if (pinout_ff == iir_pkg::PINOUT_COMPAT)
    begin
      intaPinOut  <= (trigN_ff == iir_pkg::TRIG_EDGE) ? primIrq : !primIrq;
      irq15PinOut <= (trigN_ff == iir_pkg::TRIG_EDGE) ? secIrq : !secIrq;
      intaPinOeN  <= 1'b0;
      irq15PinOeN <= 1'b0;
      irq14PinOut <= primIrq;
      irq14PinOeN <= !legacyMode;
    end
    else if (legacyMode)
    begin
      intaPinOut  <= 1'b1;
      intaPinOeN  <= 1'b1;
      irq15PinOut <= secIrq;
      irq15PinOeN <= 1'b0;
      irq14PinOut <= primIrq;
      irq14PinOeN <= 1'b0;
    end
    else
    begin
      intaPinOut  <= !(primIrq || secIrq);
      intaPinOeN  <= 1'b0;
      irq15PinOut <= 1'b0;
      irq15PinOeN <= 1'b1;
      irq14PinOut <= 1'b0;
      irq14PinOeN <= 1'b1;
    end
  end

  // helper: counts the current low run of drive reset
  logic [iir_pkg::DRV_RST_CNT_W:0] rstLowCnt_ff;
  always_ff @(posedge clock)
  begin
    // cleared in reset so the power-on low run starts from a known count
    if (drive_soft_reset_bit || driveResetOutN)
      rstLowCnt_ff <= '0;
    else if (!(&rstLowCnt_ff))
      rstLowCnt_ff <= rstLowCnt_ff + 1'b1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (drive_soft_reset_bit);

  drv_rst_min_a: assert property (
    $rose(driveResetOutN) |-> rstLowCnt_ff >= DrvRstCycles)
    else $error("drive reset released too early");
  strobe_start_a: assert property (
    (hostWriteStart && !hostWriteBusy) |=>
      !driveWriteStrobeN && !driveDataOeN &&
      driveDataOut == $past(hostWriteData))
    else $error("write strobe did not start");
  strobe_data_a: assert property (
    $rose(driveWriteStrobeN) |-> !driveDataOeN && $stable(driveDataOut))
    else $error("data not driven at strobe rise");
  strap_hold_a: assert property (
    strapsTaken_ff && $past(strapsTaken_ff) |->
      $stable(romEnabled) && $stable(secondaryEnabled) &&
      $stable(pinout_ff) && $stable(trigN_ff))
    else $error("strap value changed after capture");
  rev_native_a: assert property (
    strapsTaken_ff && !pinout_ff && !legacyMode |=>
      irq14PinOeN && irq15PinOeN && !intaPinOeN &&
      intaPinOut == !($past(primIrq) || $past(secIrq)))
    else $error("revised native routing wrong");
  rev_legacy_a: assert property (
    strapsTaken_ff && !pinout_ff && legacyMode |=>
      intaPinOeN && irq14PinOut == $past(primIrq) &&
      irq15PinOut == $past(secIrq))
    else $error("revised legacy routing wrong");
  compat_route_a: assert property (
    strapsTaken_ff && pinout_ff |=>
      (irq14PinOeN == !$past(legacyMode)) && !irq15PinOeN)
    else $error("compatible irq14 enable wrong");
  compat_level_a: assert property (
    strapsTaken_ff && pinout_ff && trigN_ff |=>
      intaPinOut == !$past(primIrq) && irq15PinOut == !$past(secIrq))
    else $error("level polarity wrong");
  rom_select_a: assert property (
    strapsTaken_ff && romEnabled && romReadActive |=>
      !romSelPinOut ##0 !romSelPinOeN)
    else $error("rom select not asserted");
  smi_out_a: assert property (
    strapsTaken_ff && !romEnabled && sysMgmtEvent |=> !romSelPinOut)
    else $error("management irq not asserted");
  latch_pulse_a: assert property (
    latchPinOut |-> romEnabled ##1 !latchPinOut)
    else $error("address latch pulse wrong");
endmodule // iir_ide_irq_routing
`default_nettype wire

// ### inc/iir_pkg.sv
// constants shared by the ide interrupt routing and strap block
`default_nettype none
package iir_pkg;
  // clock rate in MHz, period in ns
  localparam int CLK_FREQ_MHZ = 50;
  localparam int CLK_PERIOD_NS = 20;
  // drive reset least low time, microseconds
  localparam int DRV_RST_US = 25;
  localparam int DRV_RST_CYC = DRV_RST_US * CLK_FREQ_MHZ;
  localparam int DRV_RST_CNT_W = 11;
  // write strobe least low time, ns; rounded up to cycles
  localparam int WR_LOW_NS = 60;
  localparam int WR_LOW_CYC =
    (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CNT_W = 4;
  localparam int DATA_W = 16;
  // strap values after reset, before capture (user defaults)
  localparam logic RST_CHAN_CFG = 1'h0;
  localparam logic RST_ROM_EN_N = 1'h1;
  localparam logic RST_TEST_N = 1'h1;
  localparam logic RST_TRIG_N = 1'h0;
  localparam logic RST_PINOUT = 1'h1;
  // strap encodings
  localparam logic CHAN_BOTH = 1'h0;
  localparam logic ROM_ENABLED = 1'h0;
  localparam logic TEST_MODE = 1'h0;
  localparam logic TRIG_EDGE = 1'h0;
  localparam logic PINOUT_COMPAT = 1'h1;
  typedef enum logic [2:0] {
    IIR_WR_IDLE   = 3'h1,
    IIR_WR_STROBE = 3'h2,
    IIR_WR_HOLD   = 3'h4
  } iir_wr_e;
endpackage
`default_nettype wire

// ### src/iir_sync2.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ns
`default_nettype none
module iir_sync2
(
  input  wire logic clock,
  input  wire logic pinIn,
  output var  logic syncOut
);
  logic stage1_ff;
  // no reset: strap levels must flow through while drive_soft_reset_bit is held
  always_ff @(posedge clock)
  begin
    stage1_ff <= pinIn;
    syncOut   <= stage1_ff;
  end
endmodule // iir_sync2
`default_nettype wire

// ### bench/iir_drive_model.sv
// behavioural ide drive: interrupt request and write data capture
`timescale 1ns/1ns
`default_nettype none
module iir_drive_model
(
  input  wire logic                       clock,
  input  wire logic                       driveResetOutN,
  input  wire logic                       blockStart,
  input  wire logic                       hostAccess,
  input  wire logic                       strobeN,
  input  wire logic [iir_pkg::DATA_W-1:0] dataBus,
  output var  logic                       irqOut,
  output var  logic [iir_pkg::DATA_W-1:0] lastWrite
);
  logic strobeNPrev;
  // raise only when a block starts
  // drop on drive reset or host access
  always_ff @(posedge clock)
  begin
    if (!driveResetOutN || hostAccess)
      irqOut <= 1'h0;
    else if (blockStart)
      irqOut <= 1'h1;
  end
  always_ff @(posedge clock)
  begin
    strobeNPrev <= strobeN;
    if (strobeN && !strobeNPrev)
      lastWrite <= dataBus;
  end
endmodule // iir_drive_model
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the irq routing and strap block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int DRV = 10;
  localparam int WRL = 3;
  logic clock = 1'h0, drive_soft_reset_bit = 1'h1, chanPin = 1'h0, testPin = 1'h1;
  logic romPinN = 1'h0, trigPinN = 1'h0, pinoutPin = 1'h1;
  logic legacyMode = 1'h1, romAddrLoad = 1'h0, romReadActive = 1'h0;
  logic sysMgmtEvent = 1'h0, driveResetReq = 1'h0, hostWriteStart = 1'h0;
  logic [15:0] hostWriteData = 16'h0, driveDataOut, busWire, lastP, lastS;
  logic blkP = 1'h0, blkS = 1'h0, ackP = 1'h0, ackS = 1'h0;
  logic pIrq, sIrq, latchOut, latchOeN, romSelOut, romSelOeN, busy, strobeN;
  logic dataOeN, drvRstN, intaO, intaE, i15O, i15E, i14O, i14E;
  logic secEn, rom_enable_strap, testAct;
  int fails = 0, cmpCount = 0, n;
  // undriven shared pins fall back to their board straps
  wire logic latchWire = latchOeN ? chanPin : latchOut;
  wire logic romSelWire = romSelOeN ? testPin : romSelOut;
  // data bus has a pull-up when released
  assign busWire = dataOeN ? 16'hffff : driveDataOut;
  always #10 clock = ~clock;
  iir_ide_irq_routing #(.WrLowCycles(WRL), .DrvRstCycles(DRV)) dut (
    .clock(clock), .drive_soft_reset_bit(drive_soft_reset_bit), .primaryDriveIrqIn(pIrq),
    .secondaryDriveIrqIn(sIrq), .romEnableStrapN(romPinN),
    .irqTriggerStrapN(trigPinN), .irqPinoutStrap(pinoutPin),
    .latchPinIn(latchWire), .latchPinOut(latchOut), .latchPinOeN(latchOeN),
    .romSelPinIn(romSelWire), .romSelPinOut(romSelOut),
    .romSelPinOeN(romSelOeN), .legacyMode(legacyMode),
    .romAddrLoad(romAddrLoad), .romReadActive(romReadActive),
    .sysMgmtEvent(sysMgmtEvent), .driveResetReq(driveResetReq),
    .hostWriteStart(hostWriteStart), .hostWriteData(hostWriteData),
    .hostWriteBusy(busy), .driveWriteStrobeN(strobeN),
    .driveDataOut(driveDataOut), .driveDataOeN(dataOeN),
    .driveResetOutN(drvRstN), .intaPinOut(intaO), .intaPinOeN(intaE),
    .irq15PinOut(i15O), .irq15PinOeN(i15E), .irq14PinOut(i14O),
    .irq14PinOeN(i14E), .secondaryEnabled(secEn), .romEnabled(rom_enable_strap),
    .testModeActive(testAct));
  iir_drive_model drvP (.clock(clock), .driveResetOutN(drvRstN),
    .blockStart(blkP), .hostAccess(ackP), .strobeN(strobeN),
    .dataBus(busWire), .irqOut(pIrq), .lastWrite(lastP));
  iir_drive_model drvS (.clock(clock), .driveResetOutN(drvRstN),
    .blockStart(blkS), .hostAccess(ackS), .strobeN(strobeN),
    .dataBus(busWire), .irqOut(sIrq), .lastWrite(lastS));

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    cmpCount++;
    if (got !== exp)
    begin
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      fails++;
    end
  endtask

  // counts low cycles of drive reset; gives up after a bounded wait
  // pre: low cycles the caller has already watched go by
  task automatic waitDrvRst(input int pre);
    n = pre;
    while (drvRstN !== 1'h1 && n < 60)
    begin
      @(negedge clock);
      if (drvRstN !== 1'h1)
        n++;
    end
    chk(16'(n >= DRV && n <= DRV + 1), 16'h1, "drive reset length");
    if (n >= 60)
      summarize();
  endtask

  task automatic doReset(input logic ch, input logic rn, input logic tn,
                         input logic po, input logic tp);
    @(posedge clock);
    {chanPin, romPinN, trigPinN, pinoutPin, testPin} <= {ch, rn, tn, po, tp};
    drive_soft_reset_bit <= 1'h1;
    repeat (4) @(posedge clock);
    drive_soft_reset_bit <= 1'h0;
    // counting starts at the release edge, where the low run is timed from
    waitDrvRst(0);
    // later pin changes must not reach the captured straps
    @(posedge clock);
    {romPinN, trigPinN, pinoutPin} <= ~{rn, tn, po};
    repeat (4) @(negedge clock);
    chk(16'(secEn), 16'(!ch), "channel strap");
    chk(16'(rom_enable_strap), 16'(!rn), "rom strap");
    chk(16'(testAct), 16'(!tp), "test strap");
    chk(16'({latchOeN, romSelOeN}), 16'h0, "shared pins driven");
  endtask

  task automatic scnWrite(input logic [15:0] d);
    @(posedge clock);
    hostWriteData <= d;
    hostWriteStart <= 1'h1;
    @(posedge clock);
    hostWriteStart <= 1'h0;
    n = 0;
    while (strobeN !== 1'h0 && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    chk(16'(n < 8), 16'h1, "write strobe starts");
    chk(busWire, d, "data while strobe low");
    n = 0;
    while (strobeN === 1'h0 && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    chk(16'(n), 16'(WRL), "strobe low time");
    chk(busWire, d, "data held past strobe rise");
    n = 0;
    while (busy !== 1'h0 && n < 12)
    begin
      @(negedge clock);
      n++;
    end
    chk(16'(n < 12), 16'h1, "write completes");
    chk(16'(dataOeN), 16'h1, "data bus released");
    chk(lastP, d, "primary drive captured word");
    chk(lastS, d, "secondary drive captured word");
    if (n >= 12)
      summarize();
  endtask

  task automatic romPins(input logic en);
    @(posedge clock);
    romAddrLoad <= 1'h1;
    @(posedge clock);
    romAddrLoad <= 1'h0;
    @(negedge clock);
    chk(16'(latchOut), 16'(en), "latch pulse");
    @(negedge clock);
    chk(16'(latchOut), 16'h0, "latch pulse one cycle");
    @(posedge clock);
    romReadActive <= 1'h1;
    repeat (2) @(negedge clock);
    chk(16'(romSelOut), 16'(!en), "rom select on read");
    @(posedge clock);
    romReadActive <= 1'h0;
    sysMgmtEvent <= 1'h1;
    repeat (2) @(negedge clock);
    chk(16'(romSelOut), 16'(en), "smi on event");
    @(posedge clock);
    sysMgmtEvent <= 1'h0;
    repeat (2) @(negedge clock);
    chk(16'(romSelOut), 16'h1, "shared pin idle");
  endtask

  // exp: {inta, intaOeN, irq15, irq15OeN, irq14, irq14OeN}
  task automatic route(input logic leg, input logic p, input logic s,
                       input logic [5:0] exp);
    logic [5:0] got;
    @(posedge clock);
    legacyMode <= leg;
    {blkP, ackP, blkS, ackS} <= {p, !p, s, !s};
    @(posedge clock);
    {blkP, ackP, blkS, ackS} <= 4'h0;
    repeat (5) @(negedge clock);
    got = {intaO, intaE, i15O, i15E, i14O, i14E};
    for (int i = 0; i < 3; i++)
      if (exp[2*i])
        got[2*i+1] = exp[2*i+1];
    chk(16'(got), 16'(exp), "irq pins");
  endtask

  initial
  begin
    // test strap pulled high for user mode
    doReset(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    scnWrite(16'ha5c3);
    scnWrite(16'h3c5a);
    romPins(1'h1);
    route(1'h1, 1'h1, 1'h0, 6'b100010);
    route(1'h1, 1'h0, 1'h1, 6'b001000);
    route(1'h0, 1'h1, 1'h0, 6'b100001);
    route(1'h1, 1'h1, 1'h0, 6'b100010);
    @(posedge clock);
    driveResetReq <= 1'h1;
    @(posedge clock);
    driveResetReq <= 1'h0;
    repeat (2) @(negedge clock);
    chk(16'({drvRstN, pIrq}), 16'h0, "drive reset drops irq");
    // two low cycles already passed since the request was taken
    waitDrvRst(2);
    doReset(1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
    romPins(1'h0);
    route(1'h1, 1'h1, 1'h0, 6'b001010);
    route(1'h1, 1'h0, 1'h1, 6'b101000);
    // revised pinout chosen for the route runs before the final compatible reset
    doReset(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    route(1'h1, 1'h1, 1'h0, 6'b010010);
    route(1'h1, 1'h0, 1'h1, 6'b011000);
    route(1'h0, 1'h1, 1'h0, 6'b000101);
    route(1'h0, 1'h0, 1'h1, 6'b000101);
    route(1'h0, 1'h0, 1'h0, 6'b100101);
    doReset(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    summarize();
  end
endmodule // testbench
`default_nettype wire
